// ==== verilog/embc_params.svh ====
// Purpose: Constants for the external memory bus controller
// Assumes: 125 MHz sys_clk
// Notes:   Offsets, field positions and counts as macros
`ifndef EMBC_PARAMS_SVH
`define EMBC_PARAMS_SVH

// Configuration byte fields
`define EMBC_CFG_WIDTH_BIT   1
`define EMBC_CFG_STROBE_BIT  2
`define EMBC_CFG_WRMODE_BIT  3
`define EMBC_CFG_RESET       8'hFF

// Steered code region
`define EMBC_ROM_LO          16'h2000
`define EMBC_ROM_HI          16'h5FFF

// Non-maskable interrupt vector location
`define EMBC_NMI_VECTOR      16'h203E

// Clock output divide ratio
`define EMBC_CLK_DIV         2

// Edges of synchroniser delay on ready and read data
`define EMBC_SYNC_LAG        2

`endif

// ==== verilog/embc_pkg.sv ====
// Purpose: Types for the external memory bus controller
// Assumes: Constants live in embc_params.svh
// Notes:   Request and pin groups travel as packed structs
package embc_pkg;

    typedef struct packed {
        logic        valid;   // Request present
        logic        write;   // 1 write, 0 read
        logic        fetch;   // Instruction fetch
        logic        word;    // 16-bit access wanted
        logic [15:0] addr;    // Byte address
        logic [15:0] wdata;   // Write data
    } embc_req_t;

    typedef struct packed {
        logic        strobe_n;  // Address latch / valid pin
        logic        rd_n;      // Read strobe
        logic        wr_n;      // Write / low byte store strobe
        logic        hi_n;      // Upper lane enable / high byte store
        logic        fetch;     // fetch_type_indicator
    } embc_pins_t;

    typedef enum logic [2:0] {
        EMBC_IDLE,
        EMBC_ADDR,
        EMBC_DATA,
        EMBC_WAIT,
        EMBC_DONE
    } embc_state_t;

endpackage

// ==== verilog/embc_sync.sv ====
// Purpose: Two-flop synchroniser for pin inputs
// Assumes: Inputs asynchronous to sys_clk
// Notes:   First flop read only by second
`timescale 1ns/100ps
`default_nettype none
module embc_sync #(
    parameter int W = 1
) (
    input  wire logic         sys_clk, // Clock
    input  wire logic         rst,     // Async reset
    input  wire logic [W-1:0] d,       // Asynchronous in
    output logic      [W-1:0] q        // Synchronised out
);
    logic [W-1:0] meta_q;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            meta_q <= '0;
            q      <= '0;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule
`default_nettype wire

// ==== verilog/embc_clkdiv.sv ====
// Purpose: Clock output at half the input clock
// Assumes: sys_clk stands for the oscillator
// Notes:   Output straight from a flip-flop
`timescale 1ns/100ps
`default_nettype none
`include "embc_params.svh"
module embc_clkdiv (
    input  wire logic sys_clk, // Clock
    input  wire logic rst,     // Async reset
    output logic      clk_out  // Divided clock
);
    localparam logic [1:0] DIV_LAST = 2'(`EMBC_CLK_DIV / 2 - 1);
    logic [1:0] cnt_q;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cnt_q   <= 2'h0;
            clk_out <= 1'b0;
        end else if (cnt_q == DIV_LAST) begin
            cnt_q   <= 2'h0;
            clk_out <= ~clk_out;
        end else begin
            cnt_q   <= cnt_q + 2'h1;
        end
    end
endmodule
`default_nettype wire

// ==== verilog/embc_top.sv ====
// Purpose: External multiplexed memory bus control and strobes
// Assumes: One clock, core issues requests, pins synchronised here
// Notes:   One bus state per sys_clk cycle
`timescale 1ns/100ps
`default_nettype none
`include "embc_params.svh"
module embc_top (
    input  wire logic               sys_clk,              // Clock, 125 MHz
    input  wire logic               rst,                  // Async reset, high
    input  wire logic [7:0]         chip_config_byte,     // Bus configuration
    input  wire embc_pkg::embc_req_t req,                 // Core request
    output logic                    req_ready,            // Request taken
    output logic                    rsp_valid,            // Access done pulse
    output logic [15:0]             rsp_rdata,            // Read data
    output logic                    rsp_internal,         // Done went on-chip
    input  wire logic [15:0]        rom_rdata,            // On-chip ROM data
    output logic                    nmi_req,              // NMI request pulse
    output logic [15:0]             nmi_vector,           // NMI vector location
    input  wire logic               nonmaskable_irq,      // NMI pin
    input  wire logic               memory_source_select, // Code source pin
    input  wire logic               lane_size_select,     // Bus width pin
    input  wire logic               ready,                // Ready pin
    output logic                    system_clock_output,  // Clock out
    output embc_pkg::embc_pins_t     pins,                 // Strobe pins
    input  wire logic [15:0]        ad_in,                // AD bus in
    output logic [15:0]             ad_out,               // AD bus out
    output logic [15:0]             ad_oe                 // AD bus drive enable
);
    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [3:0]  pin_raw;
    logic [3:0]  pin_s;
    logic [15:0] ad_s;
    assign pin_raw = {nonmaskable_irq, memory_source_select, lane_size_select, ready};

    embc_sync #(.W(4)) u_sync_pins (
        .sys_clk (sys_clk),
        .rst     (rst),
        .d       (pin_raw),
        .q       (pin_s)
    );
    embc_sync #(.W(16)) u_sync_ad (
        .sys_clk (sys_clk),
        .rst     (rst),
        .d       (ad_in),
        .q       (ad_s)
    );

    wire nmi_s   = pin_s[3];
    wire ea_s    = pin_s[2];
    wire width_s = pin_s[1];
    wire ready_s = pin_s[0];

    embc_clkdiv u_clkdiv (
        .sys_clk (sys_clk),
        .rst     (rst),
        .clk_out (system_clock_output)
    );

    // ------------------------------------------------------------
    // Non-maskable interrupt edge
    // ------------------------------------------------------------
    logic nmi_prev_q;
    wire  nmi_rise = nmi_s & ~nmi_prev_q;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            nmi_prev_q <= 1'b0;
            nmi_req    <= 1'b0;
            nmi_vector <= 16'h0000;
        end else begin
            nmi_prev_q <= nmi_s;
            nmi_req    <= nmi_rise;
            nmi_vector <= `EMBC_NMI_VECTOR;
        end
    end

    // ------------------------------------------------------------
    // Request decode
    // ------------------------------------------------------------
    wire cfg_dyn_width = chip_config_byte[`EMBC_CFG_WIDTH_BIT];
    wire cfg_valid_lvl = chip_config_byte[`EMBC_CFG_STROBE_BIT];
    wire cfg_byte_wr   = chip_config_byte[`EMBC_CFG_WRMODE_BIT];
    wire in_rom_range  = (req.addr >= `EMBC_ROM_LO) && (req.addr <= `EMBC_ROM_HI);
    wire go_internal   = in_rom_range & ea_s;
    wire bus_wide      = cfg_dyn_width & width_s;

    // ------------------------------------------------------------
    // Bus sequencer
    // ------------------------------------------------------------
    embc_pkg::embc_state_t state_q, state_d;
    embc_pkg::embc_req_t   cur_q;
    logic                  wide_q;
    logic                  second_q;
    logic                  split_q;
    logic [15:0]           rdata_q;
    logic                  int_q;
    logic                  gap_q;
    logic [1:0]            dwell_q;

    localparam logic [1:0] DWELL_LAST = 2'(`EMBC_SYNC_LAG);

    // Ready and read data arrive two edges late, so the data
    // phase lasts until both belong to this bus cycle
    wire  in_data    = (state_q == embc_pkg::EMBC_DATA) || (state_q == embc_pkg::EMBC_WAIT);
    wire  take       = (state_q == embc_pkg::EMBC_IDLE) && req.valid;
    wire  data_end   = in_data && (dwell_q == DWELL_LAST) && ready_s;
    wire  need_more  = split_q && !second_q;

    always_comb begin
        state_d = state_q;
        case (state_q)
            embc_pkg::EMBC_IDLE: begin
                if (take && !go_internal)
                    state_d = embc_pkg::EMBC_ADDR;
                else if (take)
                    state_d = embc_pkg::EMBC_DONE;
            end
            embc_pkg::EMBC_ADDR: state_d = embc_pkg::EMBC_DATA;
            embc_pkg::EMBC_DATA,
            embc_pkg::EMBC_WAIT: begin
                if (!data_end)
                    state_d = embc_pkg::EMBC_WAIT;
                else
                    state_d = embc_pkg::EMBC_DONE;
            end
            // Strobes idle one state between the halves of a split word
            embc_pkg::EMBC_DONE: state_d = gap_q ? embc_pkg::EMBC_ADDR : embc_pkg::EMBC_IDLE;
            default:             state_d = embc_pkg::EMBC_IDLE;
        endcase
    end

    // Byte lane selection for current bus cycle
    wire [15:0] cyc_addr = second_q ? (cur_q.addr | 16'h0001) : cur_q.addr;
    wire        odd_byte = cyc_addr[0];
    wire        wide_wr  = wide_q & cur_q.word;
    wire        lo_write = cur_q.write & (wide_wr | ~odd_byte);
    wire        hi_write = cur_q.write & (wide_wr | odd_byte);
    wire [15:0] wr_word  = (!wide_q && odd_byte) ? {8'h00, cur_q.wdata[15:8]} : cur_q.wdata;

    // ------------------------------------------------------------
    // Sequencer state
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_q <= embc_pkg::EMBC_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // ------------------------------------------------------------
    // Request held for the whole access
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cur_q   <= '0;
            wide_q  <= 1'b0;
            split_q <= 1'b0;
            int_q   <= 1'b0;
        end else if (take) begin
            cur_q   <= req;
            wide_q  <= bus_wide;
            split_q <= req.word & ~bus_wide & ~req.addr[0];
            int_q   <= go_internal;
        end
    end

    // ------------------------------------------------------------
    // Split word progress and data phase length
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            second_q <= 1'b0;
            gap_q    <= 1'b0;
            dwell_q  <= 2'h0;
        end else begin
            gap_q <= data_end & need_more;
            if (take)
                second_q <= 1'b0;
            else if (data_end && need_more)
                second_q <= 1'b1;
            if (!in_data)
                dwell_q <= 2'h0;
            else if (dwell_q != DWELL_LAST)
                dwell_q <= dwell_q + 2'h1;
        end
    end

    // ------------------------------------------------------------
    // Read data gathered lane by lane
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rdata_q <= 16'h0000;
        end else if (take) begin
            rdata_q <= go_internal ? rom_rdata : 16'h0000;
        end else if (data_end && !cur_q.write) begin
            if (wide_q)
                rdata_q <= ad_s;
            else if (second_q)
                rdata_q <= {ad_s[7:0], rdata_q[7:0]};
            else if (odd_byte)
                rdata_q <= {ad_s[7:0], 8'h00};
            else
                rdata_q <= {8'h00, ad_s[7:0]};
        end
    end

    // ------------------------------------------------------------
    // Pin outputs, all registered
    // ------------------------------------------------------------
    embc_pkg::embc_pins_t pins_d;
    wire next_ext  = (state_d == embc_pkg::EMBC_ADDR) || (state_d == embc_pkg::EMBC_DATA)
                     || (state_d == embc_pkg::EMBC_WAIT);
    wire next_addr = state_d == embc_pkg::EMBC_ADDR;
    wire next_data = (state_d == embc_pkg::EMBC_DATA) || (state_d == embc_pkg::EMBC_WAIT);
    wire nx_write  = take ? req.write : cur_q.write;
    wire nx_fetch  = take ? req.fetch : cur_q.fetch;
    wire rsp_last  = (state_q == embc_pkg::EMBC_DONE) && !gap_q;

    always_comb begin
        pins_d = '1;
        pins_d.fetch = 1'b0;
        if (next_ext) begin
            pins_d.strobe_n = cfg_valid_lvl ? 1'b0 : ~next_addr;
            pins_d.fetch    = ~nx_write & nx_fetch;
        end
        if (next_data) begin
            pins_d.rd_n = nx_write;
            if (nx_write) begin
                pins_d.wr_n = cfg_byte_wr ? ~lo_write : 1'b0;
                pins_d.hi_n = ~hi_write;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pins <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
        end else begin
            pins <= pins_d;
        end
    end

    // ------------------------------------------------------------
    // Core handshake
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            req_ready    <= 1'b0;
            rsp_valid    <= 1'b0;
            rsp_internal <= 1'b0;
            rsp_rdata    <= 16'h0000;
        end else begin
            req_ready    <= state_d == embc_pkg::EMBC_IDLE;
            rsp_valid    <= rsp_last;
            rsp_internal <= rsp_last & int_q;
            rsp_rdata    <= rdata_q;
        end
    end

    // ------------------------------------------------------------
    // Address then data on the shared lanes
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ad_out <= 16'h0000;
            ad_oe  <= 16'h0000;
        end else if (next_addr) begin
            ad_out <= take ? req.addr : cyc_addr;
            ad_oe  <= 16'hFFFF;
        end else if (next_data && nx_write) begin
            ad_out <= wr_word;
            ad_oe  <= wide_q ? 16'hFFFF : 16'h00FF;
        end else begin
            ad_oe  <= 16'h0000;
        end
    end
endmodule
`default_nettype wire

// ==== bench/embc_monitor.sv ====
// Purpose: Port assertions for embc_top
// Assumes: One clock, rst async high
// Notes:   Bound to every embc_top
`timescale 1ns/100ps
`default_nettype none
module embc_monitor (
    input wire logic                 sys_clk,             // Clock
    input wire logic                 rst,                 // Reset
    input wire logic                 rsp_valid,           // Done
    input wire logic                 rsp_internal,        // On-chip
    input wire logic                 nmi_req,             // NMI pulse
    input wire logic [15:0]          nmi_vector,          // Vector
    input wire logic                 nonmaskable_irq,     // NMI pin
    input wire logic                 system_clock_output, // Clock out
    input wire embc_pkg::embc_pins_t pins,                // Strobes
    input wire logic [15:0]          ad_oe                // AD enable
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    clk_half_a: assert property (
        !$past(rst) |-> system_clock_output != $past(system_clock_output)) else $error("clock out stuck");
    nmi_edge_a: assert property (
        $rose(nonmaskable_irq) |-> ##[1:5] nmi_req) else $error("nmi edge lost");
    nmi_vec_a: assert property (
        nmi_req |=> !nmi_req && nmi_vector == 16'h203E) else $error("nmi pulse or vector wrong");
    fetch_ext_a: assert property (
        $rose(pins.fetch) |-> !pins.strobe_n && pins.wr_n) else $error("fetch outside read");
    int_quiet_a: assert property (
        rsp_internal |-> rsp_valid && pins.strobe_n && pins.rd_n) else $error("on-chip access on bus");
    strb_end_a: assert property (
        rsp_valid |-> pins.strobe_n && pins.rd_n && pins.wr_n && pins.hi_n) else $error("strobe left low");
    rd_only_a: assert property (
        !pins.rd_n |-> ad_oe == 16'h0000 && pins.wr_n && pins.hi_n) else $error("read strobe misuse");
    wr_only_a: assert property (
        !(pins.wr_n && pins.hi_n) |-> pins.rd_n && !pins.fetch) else $error("write strobe misuse");
endmodule
bind embc_top embc_monitor u_mon (.sys_clk(sys_clk), .rst(rst), .rsp_valid(rsp_valid),
    .rsp_internal(rsp_internal), .nmi_req(nmi_req), .nmi_vector(nmi_vector),
    .nonmaskable_irq(nonmaskable_irq), .system_clock_output(system_clock_output),
    .pins(pins), .ad_oe(ad_oe));
`default_nettype wire

// ==== bench/embc_ext_mem.sv ====
// Purpose: External memory on the multiplexed bus
// Assumes: Strobes active low, pull-ups on AD
// Notes:   Counts bus activity for the bench
`timescale 1ns/100ps
`default_nettype none
module embc_ext_mem (
    input  wire logic                 sys_clk,  // Clock
    input  wire logic                 rst,      // Reset
    input  wire embc_pkg::embc_pins_t pins,     // Strobes
    input  wire logic [15:0]          ad_out,   // Device drive
    input  wire logic [15:0]          ad_oe,    // Device enable
    input  wire logic                 wide,     // 16-bit cycle
    input  wire logic [3:0]           wait_cyc, // Wait states
    input  wire logic                 clr,      // Clear counts
    output logic      [15:0]          ad_in,    // Bus level
    output logic                      ready,    // Ready pin
    output logic      [7:0]           ncyc,     // Bus cycles
    output logic      [7:0]           nrd,      // Read low cycles
    output logic      [15:0]          wword,    // Written lanes
    output logic      [2:0]           seen      // Fetch, hi, lo
);
    logic [15:0] addr_q;
    logic        stb_q;
    logic [3:0]  cnt_q;
    logic [15:0] drv;
    function automatic logic [7:0] mb(input logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ 8'hA5;
    endfunction
    assign drv = wide ? {mb(addr_q | 16'h1), mb(addr_q & 16'hFFFE)} : {8'hFF, mb(addr_q)};
    // Released lanes float to the pull-up level
    assign ad_in = (ad_oe & ad_out) | (~ad_oe & (pins.rd_n ? 16'hFFFF : drv));
    // Low while idle when waits are asked for, so idle ready is tested
    assign ready = cnt_q >= wait_cyc;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            stb_q <= 1'b1;
            cnt_q <= 4'h0;
            addr_q <= 16'h0000;
        end else begin
            stb_q <= pins.strobe_n;
            cnt_q <= (pins.strobe_n && pins.rd_n && pins.wr_n && pins.hi_n) ? 4'h0
                     : cnt_q + {3'h0, cnt_q != 4'hF};
            if (!pins.strobe_n && stb_q) begin
                addr_q <= ad_out;
            end
        end
    end
    always_ff @(posedge sys_clk) begin
        if (!pins.strobe_n && stb_q) ncyc <= ncyc + 8'h1;
        if (!pins.rd_n) nrd <= nrd + 8'h1;
        if (!pins.wr_n) {wword[7:0], seen[0]} <= {ad_out[7:0], 1'b1};
        if (!pins.hi_n) {wword[15:8], seen[1]} <= {ad_out[15:8], 1'b1};
        if (pins.fetch && !pins.rd_n) seen[2] <= 1'b1;
        if (clr) {ncyc, nrd, seen} <= '0;
    end
endmodule
`default_nettype wire

// ==== bench/external_memory_bus_control_tb.sv ====
// Purpose: Self-checking bench for embc_top
// Assumes: 125 MHz sys_clk, inputs moved 1 ns after edges
// Notes:   Expected data computed here, not read back
`timescale 1ns/100ps
`default_nettype none
module external_memory_bus_control_tb;
    logic sys_clk = 1'b0, rst = 1'b1, nmi, mss, lane, clr, r, f, in_rom;
    logic [7:0] cfg, ncyc, nrd;
    logic [15:0] rom, a, d, rdat, rsp_rdata, nmi_vector, ad_in, ad_out, ad_oe, wword;
    logic [3:0] wc;
    logic [2:0] seen;
    logic req_ready, rsp_valid, rsp_internal, rint, nmi_req, sco, ready;
    embc_pkg::embc_req_t req;
    embc_pkg::embc_pins_t pins;
    logic [15:0] edge_a [4] = '{16'h1FFE, 16'h2000, 16'h5FFE, 16'h6000};
    int n_errors = 0, compares = 0, seed = 8603, i, k, l, j;
    always #4 sys_clk = ~sys_clk;
    embc_top dut (.sys_clk(sys_clk), .rst(rst), .chip_config_byte(cfg), .req(req), .req_ready(req_ready),
        .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .rsp_internal(rsp_internal), .rom_rdata(rom),
        .nmi_req(nmi_req), .nmi_vector(nmi_vector), .nonmaskable_irq(nmi), .memory_source_select(mss),
        .lane_size_select(lane), .ready(ready), .system_clock_output(sco), .pins(pins),
        .ad_in(ad_in), .ad_out(ad_out), .ad_oe(ad_oe));
    embc_ext_mem mem (.sys_clk(sys_clk), .rst(rst), .pins(pins), .ad_out(ad_out), .ad_oe(ad_oe),
        .wide(cfg[1] & lane), .wait_cyc(wc), .clr(clr), .ad_in(ad_in), .ready(ready), .ncyc(ncyc),
        .nrd(nrd), .wword(wword), .seen(seen));
    function automatic logic [7:0] bm(input logic [15:0] x);
        return x[7:0] ^ x[15:8] ^ 8'hA5;
    endfunction
    task chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task access(input logic w, input logic fe, input logic wd, input logic [15:0] ad, input logic [15:0] dd);
        clr = 1'b1;
        @(posedge sys_clk);
        #1 clr = 1'b0;
        req = '{1'b1, w, fe, wd, ad, dd};
        do begin
            r = req_ready;
            @(posedge sys_clk);
        end while (r !== 1'b1);
        #1 req.valid = 1'b0;
        i = 0;
        while (rsp_valid !== 1'b1 && i < 200) begin
            @(posedge sys_clk);
            #1 i++;
        end
        chk(i < 200, 1);
        rdat = rsp_rdata;
        rint = rsp_internal;
    endtask
    task complete_run;
        $display("Errors %0d, compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        #200000 n_errors++;
        complete_run;
    end
    initial begin
        {nmi, mss, lane, clr, wc, rom} = '0;
        cfg = 8'hFF;
        req = '0;
        repeat (4) @(posedge sys_clk);
        #1 rst = 1'b0;
        repeat (3) @(posedge sys_clk);
        #1 r = sco;
        @(posedge sys_clk);
        #1 chk(sco, {31'h0, ~r});
        for (k = 0; k < 16; k++) begin
            cfg = 8'hF1 | {4'h0, k[2:0], 1'b0};
            lane = k[3];
            wc = 4'($random(seed) & 3);
            f = 1'($random(seed));
            a = 16'h8000 | 16'($random(seed) & 16'h7FFE);
            d = 16'($random(seed));
            repeat (3) @(posedge sys_clk);
            #1 access(1'b0, f, 1'b1, a, 16'h0);
            chk(rdat, {bm(a + 16'h1), bm(a)});
            chk(ncyc, (cfg[1] & lane) ? 1 : 2);
            chk(seen[2], f);
            chk(nrd >= 8'(wc) + 8'h1, 1);
            access(1'b1, 1'b0, 1'b1, a, d);
            chk(nrd, 0);
            if (cfg[1] & lane) chk(wword, d);
            for (j = 0; j < 2; j++) begin
                access(1'b1, 1'b0, 1'b0, a | 16'(j), d);
                if (cfg[1] & lane) chk(seen[1:0], {j[0], cfg[3] ? ~j[0] : 1'b1});
                else chk(ncyc, 1);
            end
        end
        // Ready low while idle: on-chip reads must not wait for it
        {cfg, lane, wc} = {8'hFF, 1'b1, 4'h3};
        for (k = 0; k < 8; k++) begin
            mss = k[0];
            a = edge_a[k >> 1];
            rom = 16'($random(seed));
            in_rom = mss && a >= 16'h2000 && a <= 16'h5FFF;
            repeat (3) @(posedge sys_clk);
            #1 access(1'b0, 1'b1, 1'b1, a, 16'h0);
            chk(rint, in_rom);
            chk(ncyc, in_rom ? 0 : 1);
            chk(rdat, in_rom ? rom : {bm(a + 16'h1), bm(a)});
        end
        for (k = 0; k < 2; k++) begin
            nmi = 1'b1;
            i = 0;
            while (nmi_req !== 1'b1 && i < 20) begin
                @(posedge sys_clk);
                #1 i++;
            end
            chk(i < 20, 1);
            chk(nmi_vector, 16'h203E);
            nmi = 1'b0;
            repeat (5) @(posedge sys_clk);
            #1;
        end
        complete_run;
    end
endmodule
`default_nettype wire
